// [rtl/wdt_map.vh]
// register map, field positions and timing constants of the watchdog
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// ----------------------------------------------------------------------
// register offsets (data space; i/o space is 0x20 lower)
// ----------------------------------------------------------------------
`define WDT_IO_SHIFT          8'h20
`define WDT_CAUSE_OFFSET      8'h54
`define WDT_CTRL_OFFSET       8'h60
`define WDT_CAUSE_RESET       8'h00
`define WDT_CTRL_RESET        8'h00
`define WDT_UNMAPPED_DATA     8'h00

// ----------------------------------------------------------------------
// reset_cause_flags fields
// ----------------------------------------------------------------------
`define WDT_WDOG_CAUSE_BIT    3
`define WDT_BROWNOUT_BIT      2
`define WDT_PIN_RST_BIT       1
`define WDT_POWERON_BIT       0

// ----------------------------------------------------------------------
// watchdog_control_status fields
// ----------------------------------------------------------------------
`define WDT_IRQ_FLAG_BIT      7
`define WDT_IRQ_EN_BIT        6
`define WDT_SEL3_BIT          5
`define WDT_CE_BIT            4
`define WDT_RST_EN_BIT        3
`define WDT_SEL_LO_MSB        2
`define WDT_SEL_LO_LSB        0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define WDT_SYS_CLK_HZ        100000000
`define WDT_OSC_HZ            128000
`define WDT_CE_CYCLES         3'd4
`define WDT_BASE_CYCLES       21'h000800
`define WDT_SEL_MAX           4'h9
`define WDT_CNT_W             21

`endif

// [rtl/wdt_timebase.v]
// watchdog time base: counts edges of the slow oscillator up to a timeout
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.vh"

module wdt_timebase #(
  parameter CNT_W = `WDT_CNT_W
) (
  input  wire             clock_i,
  input  wire             sys_rst_i,
  input  wire             osc_i,
  input  wire             run_i,
  input  wire             restart_i,
  input  wire [3:0]       select_i,
  output reg              timeout_o
);

  // --------------------------------------------------------------------
  // oscillator synchroniser and edge detect
  // --------------------------------------------------------------------
  reg             osc_meta;
  reg             osc_sync;
  reg             osc_last;
  reg [CNT_W-1:0] count;
  wire            osc_edge;

  assign osc_edge = osc_sync & ~osc_last;

  // reserved codes behave like the longest period rather than stop
  function [CNT_W-1:0] limit;
    input [3:0] sel;
    reg   [3:0] s;
    begin
      s = (sel > `WDT_SEL_MAX) ? `WDT_SEL_MAX : sel;
      limit = (`WDT_BASE_CYCLES << s) - 1'b1;
    end
  endfunction

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_last <= 1'b0;
    end else begin
      osc_meta <= osc_i;
      osc_sync <= osc_meta;
      osc_last <= osc_sync;
    end
  end

  // --------------------------------------------------------------------
  // counter; one system-clock pulse per timeout, then counts again from zero
  // --------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      count     <= {CNT_W{1'b0}};
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= 1'b0;
      if (restart_i || !run_i) begin
        count <= {CNT_W{1'b0}};
      end else if (osc_edge) begin
        if (count >= limit(select_i)) begin
          count     <= {CNT_W{1'b0}};
          timeout_o <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/wdt_reset_flags.v]
// watchdog timer with control register and reset-cause flag register
//
// Contract
// - watchdog system reset sets its cause flag; por or writing zero clears
// - brown-out reset sets its cause flag; por or writing zero clears it
// - pin reset sets its cause flag; por or writing zero clears it
// - power-on reset sets its flag; only writing zero clears it
// - registers decode at data offsets, and 0x20 lower for i/o accesses
// - timeout in an interrupt-giving mode sets the interrupt flag
// - vector execution or writing one clears the interrupt flag
// - interrupt requested only with global and watchdog enables both set
// - combined mode: first timeout sets flag; vector clears enable and flag
// - combined mode: unserviced flag at second timeout gives system reset
// - fuse unprogrammed: reset and interrupt enables select the mode
// - fuse programmed forces system reset mode regardless of enables
// - clearing reset enable or changing prescaler needs change enable
// - change enable clears itself four system cycles after written
// - watchdog cause flag forces reset enable to one
// - timeout is 2048 oscillator cycles shifted by select code 0..9
// - control bits: flag 7, enable 6, sel3 5, ce 4, rst 3, sel 2:0
// - counter counts the separate slow oscillator, not system clock
// - restart instruction restarts the counter before timeout
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.vh"

module wdt_reset_flags (
  input  wire       clock_i,
  input  wire       sys_rst_i,
  // core register port
  input  wire [7:0] bus_addr_i,
  input  wire       bus_io_i,
  input  wire       bus_wr_i,
  input  wire       bus_rd_i,
  input  wire [7:0] bus_wdata_i,
  output reg  [7:0] bus_rdata_o,
  // core control
  input  wire       cpu_irq_enable_i,
  input  wire       wdog_restart_i,
  input  wire       irq_ack_i,
  output wire       irq_req_o,
  // oscillator, fuse and reset sources
  input  wire       wdog_osc_i,
  input  wire       always_on_fuse_i,
  input  wire       poweron_i,
  input  wire       brownout_i,
  input  wire       pin_reset_i,
  output reg        wdog_reset_o
);

  // --------------------------------------------------------------------
  // mode codes
  // --------------------------------------------------------------------
  localparam [3:0] MODE_STOP = 4'h1;
  localparam [3:0] MODE_IRQ  = 4'h2;
  localparam [3:0] MODE_RST  = 4'h4;
  localparam [3:0] MODE_BOTH = 4'h8;

  // --------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------
  reg       wdog_reset_cause_flag;
  reg       brownout_cause_flag;
  reg       pin_reset_cause_flag;
  reg       poweron_cause_flag;
  reg       timeout_irq_flag;
  reg       timeout_irq_enable;
  reg       sys_reset_enable;
  reg [3:0] timeout_select;
  reg [2:0] ce_count;

  reg [2:0] src_meta;
  reg [2:0] src_sync;
  reg [2:0] src_last;
  reg       fuse_meta;
  reg       fuse_sync;

  reg [3:0] mode;
  reg       set_flag;
  reg       fire_reset;

  wire      change_enable;
  wire      fuse_programmed;
  wire      eff_irq_enable;
  wire      eff_reset_enable;
  wire      por_evt;
  wire      bor_evt;
  wire      pin_evt;
  wire      any_rst;
  wire      cause_hit;
  wire      ctrl_hit;
  wire      cause_wr;
  wire      ctrl_wr;
  wire      timeout;
  wire      wdog_run;
  wire      wdog_restart;
  wire [7:0] cause_view;
  wire [7:0] ctrl_view;

  // --------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------
  // same register answers at two addresses, one per access kind
  function hit;
    input [7:0] addr;
    input       io;
    input [7:0] data_off;
    begin
      if (io) begin
        hit = (addr == (data_off - `WDT_IO_SHIFT));
      end else begin
        hit = (addr == data_off);
      end
    end
  endfunction

  assign cause_hit = hit(bus_addr_i, bus_io_i, `WDT_CAUSE_OFFSET);
  assign ctrl_hit  = hit(bus_addr_i, bus_io_i, `WDT_CTRL_OFFSET);
  assign cause_wr  = bus_wr_i & cause_hit;
  assign ctrl_wr   = bus_wr_i & ctrl_hit;

  // --------------------------------------------------------------------
  // synchronisers for reset sources and fuse
  // --------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      src_meta  <= 3'h0;
      src_sync  <= 3'h0;
      src_last  <= 3'h0;
      fuse_meta <= 1'b1;
      fuse_sync <= 1'b1;
    end else begin
      src_meta  <= {poweron_i, brownout_i, pin_reset_i};
      src_sync  <= src_meta;
      src_last  <= src_sync;
      fuse_meta <= always_on_fuse_i;
      fuse_sync <= fuse_meta;
    end
  end

  // each source counts once, on its rising edge
  assign por_evt = src_sync[2] & ~src_last[2];
  assign bor_evt = src_sync[1] & ~src_last[1];
  assign pin_evt = src_sync[0] & ~src_last[0];
  assign any_rst = por_evt | bor_evt | pin_evt | wdog_reset_o;

  // --------------------------------------------------------------------
  // effective configuration and mode
  // --------------------------------------------------------------------
  assign fuse_programmed  = ~fuse_sync;
  assign change_enable    = (ce_count != 3'h0);
  // fuse locks the enables to reset on, interrupt off
  assign eff_irq_enable   = fuse_programmed ? 1'b0 : timeout_irq_enable;
  assign eff_reset_enable = fuse_programmed | sys_reset_enable;

  always @* begin
    if (fuse_programmed) begin
      mode = MODE_RST;
    end else begin
      case ({eff_reset_enable, eff_irq_enable})
        2'b00:   mode = MODE_STOP;
        2'b01:   mode = MODE_IRQ;
        2'b10:   mode = MODE_RST;
        2'b11:   mode = MODE_BOTH;
        default: mode = MODE_STOP;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // timeout action
  // --------------------------------------------------------------------
  always @* begin
    set_flag   = 1'b0;
    fire_reset = 1'b0;
    case (mode)
      MODE_IRQ: begin
        set_flag = timeout;
      end
      MODE_RST: begin
        fire_reset = timeout;
      end
      MODE_BOTH: begin
        if (timeout_irq_flag) begin
          fire_reset = timeout;
        end else begin
          set_flag = timeout;
        end
      end
      default: begin
        set_flag   = 1'b0;
        fire_reset = 1'b0;
      end
    endcase
  end

  assign irq_req_o = timeout_irq_flag & eff_irq_enable
                     & cpu_irq_enable_i;

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      wdog_reset_o <= 1'b0;
    end else begin
      // one-cycle pulse; the counter restarts behind it
      wdog_reset_o <= fire_reset;
    end
  end

  // --------------------------------------------------------------------
  // time base
  // --------------------------------------------------------------------
  assign wdog_run     = (mode != MODE_STOP);
  assign wdog_restart = wdog_restart_i | any_rst;

  wdt_timebase #(
    .CNT_W     (`WDT_CNT_W)
  ) u_timebase (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .osc_i     (wdog_osc_i),
    .run_i     (wdog_run),
    .restart_i (wdog_restart),
    .select_i  (timeout_select),
    .timeout_o (timeout)
  );

  // --------------------------------------------------------------------
  // reset-cause flags
  // --------------------------------------------------------------------
  // hardware set wins over a software clear in the same cycle; these
  // flags survive every reset source except power-on
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      wdog_reset_cause_flag <= 1'b0;
      brownout_cause_flag   <= 1'b0;
      pin_reset_cause_flag  <= 1'b0;
      poweron_cause_flag    <= 1'b0;
    end else begin
      if (wdog_reset_o) begin
        wdog_reset_cause_flag <= 1'b1;
      end else if (por_evt) begin
        wdog_reset_cause_flag <= 1'b0;
      end else if (cause_wr && !bus_wdata_i[`WDT_WDOG_CAUSE_BIT]) begin
        wdog_reset_cause_flag <= 1'b0;
      end

      if (bor_evt) begin
        brownout_cause_flag <= 1'b1;
      end else if (por_evt) begin
        brownout_cause_flag <= 1'b0;
      end else if (cause_wr && !bus_wdata_i[`WDT_BROWNOUT_BIT]) begin
        brownout_cause_flag <= 1'b0;
      end

      if (pin_evt) begin
        pin_reset_cause_flag <= 1'b1;
      end else if (por_evt) begin
        pin_reset_cause_flag <= 1'b0;
      end else if (cause_wr && !bus_wdata_i[`WDT_PIN_RST_BIT]) begin
        pin_reset_cause_flag <= 1'b0;
      end

      if (por_evt) begin
        poweron_cause_flag <= 1'b1;
      end else if (cause_wr && !bus_wdata_i[`WDT_POWERON_BIT]) begin
        poweron_cause_flag <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // control register
  // --------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      timeout_irq_flag   <= 1'b0;
      timeout_irq_enable <= 1'b0;
      sys_reset_enable   <= 1'b0;
      timeout_select     <= 4'h0;
      ce_count           <= 3'h0;
    end else if (any_rst) begin
      // a system reset reloads the register; a watchdog reset keeps
      // the reset enable on through its cause flag
      timeout_irq_flag   <= 1'b0;
      timeout_irq_enable <= 1'b0;
      sys_reset_enable   <= wdog_reset_o | wdog_reset_cause_flag;
      timeout_select     <= 4'h0;
      ce_count           <= 3'h0;
    end else begin
      // interrupt flag
      if (set_flag) begin
        timeout_irq_flag <= 1'b1;
      end else if (irq_ack_i) begin
        timeout_irq_flag <= 1'b0;
      end else if (ctrl_wr && bus_wdata_i[`WDT_IRQ_FLAG_BIT]) begin
        timeout_irq_flag <= 1'b0;
      end

      // interrupt enable; vector in combined mode drops to reset mode
      if (irq_ack_i && mode == MODE_BOTH) begin
        timeout_irq_enable <= 1'b0;
      end else if (ctrl_wr) begin
        timeout_irq_enable <= bus_wdata_i[`WDT_IRQ_EN_BIT];
      end

      // reset enable: set freely, cleared only inside the window
      if (wdog_reset_cause_flag) begin
        sys_reset_enable <= 1'b1;
      end else if (ctrl_wr) begin
        if (bus_wdata_i[`WDT_RST_EN_BIT]) begin
          sys_reset_enable <= 1'b1;
        end else if (change_enable) begin
          sys_reset_enable <= 1'b0;
        end
      end

      // prescaler changes only inside the window
      if (ctrl_wr && change_enable) begin
        timeout_select <= {bus_wdata_i[`WDT_SEL3_BIT],
          bus_wdata_i[`WDT_SEL_LO_MSB:`WDT_SEL_LO_LSB]};
      end

      // change-enable window; uses the value before this write, so
      // the opening write itself cannot change protected bits
      if (ctrl_wr && bus_wdata_i[`WDT_CE_BIT]) begin
        ce_count <= `WDT_CE_CYCLES;
      end else if (ctrl_wr) begin
        ce_count <= 3'h0;
      end else if (change_enable) begin
        ce_count <= ce_count - 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------
  assign cause_view = {4'h0, wdog_reset_cause_flag, brownout_cause_flag,
                       pin_reset_cause_flag, poweron_cause_flag};

  assign ctrl_view = {timeout_irq_flag,
                      eff_irq_enable,
                      timeout_select[3],
                      change_enable,
                      eff_reset_enable,
                      timeout_select[2:0]};

  // read data is registered and holds until the next read
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      bus_rdata_o <= `WDT_UNMAPPED_DATA;
    end else if (bus_rd_i) begin
      if (cause_hit) begin
        bus_rdata_o <= cause_view;
      end else if (ctrl_hit) begin
        bus_rdata_o <= ctrl_view;
      end else begin
        bus_rdata_o <= `WDT_UNMAPPED_DATA;
      end
    end
  end

endmodule
`default_nettype wire

// [testbench/wdt_props.sv]
// port assertions for the watchdog with reset-cause flags
`timescale 1ns/1ps
`default_nettype none
module wdt_props (
  input wire logic       clock_i,
  input wire logic       sys_rst_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic       bus_io_i,
  input wire logic       bus_rd_i,
  input wire logic [7:0] bus_rdata_o,
  input wire logic       cpu_irq_enable_i,
  input wire logic       irq_ack_i,
  input wire logic       irq_req_o,
  input wire logic       always_on_fuse_i,
  input wire logic       wdog_reset_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // io accesses sit 0x20 below the data-space offset
  wire [7:0] off = bus_addr_i + (bus_io_i ? 8'h20 : 8'h00);
  wire       hit = (off == 8'h54) || (off == 8'h60);
  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  a_reset_pulse_gap: assert property (wdog_reset_o |=> !wdog_reset_o [*8])
    else $error("watchdog reset longer than one cycle");
  a_irq_needs_gie: assert property (irq_req_o |-> cpu_irq_enable_i)
    else $error("interrupt request without global enable");
  a_fuse_no_irq: assert property (!always_on_fuse_i [*4] |-> !irq_req_o)
    else $error("interrupt request with fuse programmed");
  a_rdata_holds: assert property (
    !bus_rd_i && !$past(bus_rd_i) |=> $stable(bus_rdata_o))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (
    bus_rd_i && !hit ##1 !bus_rd_i |=> bus_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_cause_upper_zero: assert property (
    bus_rd_i && off == 8'h54 ##1 !bus_rd_i |=> bus_rdata_o[7:4] == 4'h0)
    else $error("cause register upper bits not zero");
  a_ack_clears_irq: assert property (irq_ack_i |=> !irq_req_o)
    else $error("interrupt request survived vector");
  a_reset_drops_irq: assert property (wdog_reset_o |-> ##2 !irq_req_o)
    else $error("interrupt request after watchdog reset");
  cover property (wdog_reset_o);
  cover property (irq_req_o && cpu_irq_enable_i);
  cover property (irq_ack_i && irq_req_o);
endmodule
bind wdt_reset_flags wdt_props u_props (
  .clock_i          (clock_i),
  .sys_rst_i        (sys_rst_i),
  .bus_addr_i       (bus_addr_i),
  .bus_io_i         (bus_io_i),
  .bus_rd_i         (bus_rd_i),
  .bus_rdata_o      (bus_rdata_o),
  .cpu_irq_enable_i (cpu_irq_enable_i),
  .irq_ack_i        (irq_ack_i),
  .irq_req_o        (irq_req_o),
  .always_on_fuse_i (always_on_fuse_i),
  .wdog_reset_o     (wdog_reset_o)
);
`default_nettype wire

// [testbench/wdt_osc_model.sv]
// behavioural slow oscillator feeding the watchdog time base
`timescale 1ns/1ps
`default_nettype none
module wdt_osc_model #(
  parameter int HALF = 3
) (
  input  wire logic clock_i,
  input  wire logic run_i,
  output var  logic osc_o
);
  int cnt = 0;
  initial osc_o = 1'b0;
  // stands still low when stopped so no stray edge reaches the counter
  always @(posedge clock_i) begin
    if (!run_i) begin
      cnt <= 0;
      osc_o <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      osc_o <= ~osc_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// [testbench/wdt_reset_flags_bench.sv]
// self-checking bench for the watchdog with reset-cause flags
`timescale 1ns/1ps
`default_nettype none
module wdt_reset_flags_bench;
  logic clock_i = 1'b0, sys_rst = 1'b1;
  logic [7:0] addr, wd, rdat;
  logic io, wr, rd, gie, rstrt, ack, irq, osc, fuse, por, bor, pin, wrst, run;
  logic [31:0] seed = 32'd43;
  int miscompares = 0, tests_run = 0, edges = 0, cycles = 0;
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
  always #5 clock_i = ~clock_i;
  always @(posedge osc) edges++;
  wdt_osc_model u_osc (.clock_i(clock_i), .run_i(run), .osc_o(osc));
  wdt_reset_flags u_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst), .bus_addr_i(addr),
    .bus_io_i(io), .bus_wr_i(wr), .bus_rd_i(rd), .bus_wdata_i(wd),
    .bus_rdata_o(rdat), .cpu_irq_enable_i(gie), .wdog_restart_i(rstrt),
    .irq_ack_i(ack), .irq_req_o(irq), .wdog_osc_i(osc),
    .always_on_fuse_i(fuse), .poweron_i(por), .brownout_i(bor),
    .pin_reset_i(pin), .wdog_reset_o(wrst));
  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] amap(input logic [7:0] o, input logic i);
    return i ? o - 8'h20 : o;
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic idle(input int n);
    wr = 1'b0;
    rd = 1'b0;
    repeat (n) begin
      @(posedge clock_i);
      #1;
    end
  endtask
  // strobe stays up on return so back-to-back accesses need no gap
  task automatic op(input logic w, input logic [7:0] o, input logic [7:0] d);
    logic i;
    i = rnd() & 1;
    addr = amap(o, i);
    io = i;
    wr = w;
    rd = !w;
    wd = d;
    @(posedge clock_i);
    #1;
  endtask
  task automatic rdchk(input logic [7:0] o, input logic [7:0] e);
    op(1'b0, o, 8'h00);
    idle(1);
    `CHK(rdat, e)
  endtask
  task automatic pulse(input int k);
    if (k == 0) rstrt = 1'b1; else ack = 1'b1;
    @(posedge clock_i);
    #1;
    rstrt = 1'b0;
    ack = 1'b0;
    edges = 0;
  endtask
  task automatic ev(input logic [2:0] m);
    {bor, pin, por} = m;
    idle(3);
    {bor, pin, por} = 3'b000;
    idle(4);
  endtask
  task automatic await(input bit r);
    int n;
    n = 0;
    // drop a strobe left up by op so the write is not repeated while waiting
    wr = 1'b0;
    rd = 1'b0;
    while ((r ? wrst : irq) !== 1'b1 && n < 20000) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    `CHK(n < 20000, 1'b1)
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      wrap_up();
    end
  end
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  initial begin
    {addr, io, wr, rd, wd, gie, rstrt, ack, por, bor, pin, run} = '0;
    fuse = 1'b1;
    repeat (4) @(posedge clock_i);
    #1 sys_rst = 1'b0;
    idle(3);
    rdchk(8'h54, 8'h00);
    rdchk(8'h60, 8'h00);
    for (int k = 0; k < 4; k++) rdchk(8'h80 | 8'(rnd()), 8'h00);
    $display("test registers done");
    ev(3'b001);
    rdchk(8'h54, 8'h01);
    ev(3'b110);
    rdchk(8'h54, 8'h07);
    ev(3'b001);
    rdchk(8'h54, 8'h01);
    op(1'b1, 8'h54, 8'(rnd()) & 8'hfe);
    rdchk(8'h54, 8'h00);
    $display("test cause flags done");
    op(1'b1, 8'h60, 8'h08);
    op(1'b1, 8'h60, 8'h05);
    rdchk(8'h60, 8'h08);
    op(1'b1, 8'h60, 8'h18);
    rdchk(8'h60, 8'h18);
    idle(2);
    op(1'b1, 8'h60, 8'h05);
    rdchk(8'h60, 8'h08);
    op(1'b1, 8'h60, 8'h18);
    idle(3);
    op(1'b1, 8'h60, 8'h05);
    rdchk(8'h60, 8'h05);
    op(1'b1, 8'h60, 8'h18);
    op(1'b1, 8'h60, 8'h00);
    op(1'b1, 8'h60, 8'h40);
    rdchk(8'h60, 8'h40);
    $display("test change window done");
    gie = 1'b1;
    run = 1'b1;
    pulse(0);
    idle(3000);
    pulse(0);
    await(0);
    `CHK(edges >= 2047 && edges <= 2049, 1'b1)
    gie = 1'b0;
    idle(1);
    `CHK(irq, 1'b0)
    gie = 1'b1;
    idle(1);
    `CHK(irq, 1'b1)
    op(1'b1, 8'h60, 8'hc0);
    idle(1);
    `CHK(irq, 1'b0)
    await(0);
    pulse(1);
    `CHK(irq, 1'b0)
    $display("test interrupt mode done");
    op(1'b1, 8'h60, 8'h48);
    await(0);
    rdchk(8'h60, 8'hc8);
    pulse(1);
    rdchk(8'h60, 8'h08);
    await(1);
    // the cause flag lands one edge after the reset pulse
    idle(1);
    rdchk(8'h54, 8'h08);
    rdchk(8'h60, 8'h08);
    op(1'b1, 8'h60, 8'h48);
    await(0);
    pulse(0);
    edges = 0;
    await(1);
    `CHK(edges >= 2047 && edges <= 2049, 1'b1)
    run = 1'b0;
    // let the reset pulse pass so the opening write is not swallowed
    idle(1);
    op(1'b1, 8'h60, 8'h18);
    op(1'b1, 8'h60, 8'h00);
    rdchk(8'h60, 8'h08);
    op(1'b1, 8'h54, 8'h00);
    op(1'b1, 8'h60, 8'h18);
    op(1'b1, 8'h60, 8'h00);
    rdchk(8'h60, 8'h00);
    $display("test combined mode done");
    fuse = 1'b0;
    idle(4);
    rdchk(8'h60, 8'h08);
    fuse = 1'b1;
    idle(4);
    rdchk(8'h60, 8'h00);
    $display("test fuse done");
    wrap_up();
  end
endmodule
`default_nettype wire
